// ### verilog/hcpp_top.sv
// hcpp_top: host packet port with command FIFO, return data FIFO and status
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "hcpp_cfg.svh"
module hcpp_top #(
  parameter int NUM_AXES  = `HCPP_NUM_AXES,
  parameter int CMD_DEPTH = `HCPP_CMD_DEPTH,
  parameter int RET_DEPTH = `HCPP_RET_DEPTH,
  parameter int STK_DEPTH = `HCPP_STK_DEPTH
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_i,
  // host register port
  input  wire logic [`HCPP_AW-1:0]       addr_i,
  input  wire logic [31:0]               wdata_i,
  input  wire logic                      wr_i,
  input  wire logic                      rd_i,
  output logic      [31:0]               rdata_o,
  output logic                           ready_to_receive_flag_o,
  // move complete level per axis, asynchronous
  input  wire logic [NUM_AXES-1:0]       move_done_i,
  // command executor side
  output logic                           cmd_valid_o,
  output hcpp_pkg::hcpp_cmd_t            cmd_o,
  input  wire logic                      cmd_ready_i,
  input  wire logic                      modal_err_i,
  // return data from executor
  input  wire logic                      rdat_valid_i,
  input  wire logic [15:0]               rdat_word_i,
  // execution error report
  input  wire logic                      err_valid_i,
  input  wire hcpp_pkg::hcpp_err_t       err_entry_i
);
  localparam logic [7:0] CMD_D8 = 8'(CMD_DEPTH);
  localparam logic [7:0] RET_D8 = 8'(RET_DEPTH);
  localparam logic [2:0] MAX_W  = 3'(`HCPP_MAX_WORDS);

  typedef struct packed {
    hcpp_pkg::hcpp_pkt_state_t        pst;
    hcpp_pkg::hcpp_cmd_t              asm_cmd;
    logic [2:0]                       idx;
    hcpp_pkg::hcpp_cmd_t [CMD_DEPTH-1:0] cmd_mem;
    logic [7:0]                       cmd_wp;
    logic [7:0]                       cmd_rp;
    logic [7:0]                       cmd_cnt;
    logic [RET_DEPTH-1:0][15:0]       ret_mem;
    logic [7:0]                       ret_wp;
    logic [7:0]                       ret_rp;
    logic [7:0]                       ret_cnt;
    logic                             perr;
    logic                             ovf;
    logic                             modal;
    logic [NUM_AXES-1:0]              mv_s1;
    logic [NUM_AXES-1:0]              mv_s2;
    logic [31:0]                      rdata;
  } hcpp_top_state_t;

  hcpp_top_state_t s;
  hcpp_top_state_t next_s;
  hcpp_stk_if      stk ();
  logic            wr_data;
  logic            rd_data;
  logic            rd_csr;
  logic            cmd_pop;
  logic            cmd_full;
  logic            err_msg;
  logic [15:0]     word;

  if (NUM_AXES < 1 || NUM_AXES > 32 || CMD_DEPTH < 1 || CMD_DEPTH > `HCPP_PTR_MAX ||
      RET_DEPTH < 1 || RET_DEPTH > `HCPP_PTR_MAX) begin : g_chk
    $error("unsupported parameter value");
  end

  // circular pointer step for any depth, not only powers of two
  function automatic logic [7:0] hcpp_wrap_inc(input logic [7:0] p, input logic [7:0] depth);
    return (p == depth - 8'h01) ? 8'h00 : p + 8'h01;
  endfunction : hcpp_wrap_inc

  // status word as the host sees it
  function automatic logic [31:0] hcpp_csr_word(input logic rx_rdy, input logic rts, input logic pe,
                                                input logic em, input logic ov);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`HCPP_CSR_RX_RDY]  = rx_rdy;
    w[`HCPP_CSR_RTS]     = rts;
    w[`HCPP_CSR_PKT_ERR] = pe;
    w[`HCPP_CSR_ERR_MSG] = em;
    w[`HCPP_CSR_RET_OVF] = ov;
    return w;
  endfunction : hcpp_csr_word

  // address decode of the host port
  assign word    = wdata_i[15:0];
  assign wr_data = wr_i && (addr_i == `HCPP_OFS_DATA);
  assign rd_data = rd_i && (addr_i == `HCPP_OFS_DATA);
  assign rd_csr  = rd_i && (addr_i == `HCPP_OFS_CSR);

  // command FIFO handshakes; full is the only thing that stops the host
  assign cmd_full                = (s.cmd_cnt == CMD_D8);
  assign ready_to_receive_flag_o = !cmd_full;
  assign cmd_valid_o             = (s.cmd_cnt != 8'h00);
  assign cmd_o                   = s.cmd_mem[s.cmd_rp];
  assign cmd_pop                 = cmd_valid_o && cmd_ready_i;

  // error message stays up while anything sits on the stack
  assign err_msg = !stk.empty || s.ovf || s.modal;

  // error stack connection; reads of the error register pop it
  assign stk.push       = err_valid_i;
  assign stk.push_entry = err_entry_i;
  assign stk.pop        = rd_i && (addr_i == `HCPP_OFS_ERR);

  hcpp_err_stack #(
    .DEPTH (STK_DEPTH)
  ) u_stack (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .stk       (stk)
  );

  // next state: clears are applied first so a same-cycle event wins
  always_comb begin
    next_s       = s;
    next_s.rdata = 32'h0000_0000;
    next_s.mv_s1 = move_done_i;
    next_s.mv_s2 = s.mv_s1;

    // register reads, data valid in the following cycle only
    if (rd_i) begin
      case (addr_i)
        `HCPP_OFS_DATA: begin
          if (s.ret_cnt != 8'h00) begin
            next_s.rdata  = {16'h0000, s.ret_mem[s.ret_rp]};
            next_s.ret_rp = hcpp_wrap_inc(s.ret_rp, RET_D8);
          end
        end
        `HCPP_OFS_CSR: begin
          next_s.rdata = hcpp_csr_word(!cmd_full, s.ret_cnt != 8'h00, s.perr, err_msg, s.ovf);
          next_s.perr  = 1'b0;
          next_s.ovf   = 1'b0;
          next_s.modal = 1'b0;
        end
        `HCPP_OFS_MOVE: begin
          next_s.rdata = 32'(s.mv_s2);
        end
        `HCPP_OFS_ERR: begin
          next_s.rdata = stk.top_entry;
        end
        default: begin
          next_s.rdata = 32'h0000_0000;
        end
      endcase
    end

    // packet checker on each data port write
    if (wr_data) begin
      case (s.pst)
        hcpp_pkg::PK_ID: begin
          if (word[15:12] == `HCPP_ID_MARK && word[2:0] != 3'h0 && word[2:0] <= MAX_W) begin
            next_s.asm_cmd.len   = word[2:0];
            next_s.asm_cmd.words = '0;
            next_s.idx           = 3'h0;
            next_s.pst           = hcpp_pkg::PK_BODY;
          end else begin
            next_s.perr = 1'b1;
          end
        end
        hcpp_pkg::PK_BODY: begin
          next_s.asm_cmd.words[s.idx[1:0]] = word;
          next_s.idx                       = s.idx + 3'h1;
          if (s.idx + 3'h1 == s.asm_cmd.len) begin
            next_s.pst = hcpp_pkg::PK_TERM;
          end
        end
        hcpp_pkg::PK_TERM: begin
          next_s.pst = hcpp_pkg::PK_ID;
          // a terminator that meets a full FIFO loses the packet
          if (word == `HCPP_TERM_WORD && !cmd_full) begin
            next_s.cmd_mem[s.cmd_wp] = s.asm_cmd;
            next_s.cmd_wp            = hcpp_wrap_inc(s.cmd_wp, CMD_D8);
          end else begin
            next_s.perr = 1'b1;
          end
        end
        default: begin
          next_s.pst = hcpp_pkg::PK_ID;
        end
      endcase
    end

    // command FIFO occupancy
    if (cmd_pop) begin
      next_s.cmd_rp = hcpp_wrap_inc(s.cmd_rp, CMD_D8);
    end
    next_s.cmd_cnt = s.cmd_cnt
                   + ((wr_data && s.pst == hcpp_pkg::PK_TERM && word == `HCPP_TERM_WORD && !cmd_full)
                      ? 8'h01 : 8'h00)
                   - (cmd_pop ? 8'h01 : 8'h00);

    // return data FIFO; no back-pressure, overflow is flagged instead
    if (rdat_valid_i) begin
      if (s.ret_cnt != RET_D8) begin
        next_s.ret_mem[s.ret_wp] = rdat_word_i;
        next_s.ret_wp            = hcpp_wrap_inc(s.ret_wp, RET_D8);
      end else begin
        next_s.ovf = 1'b1;
      end
    end
    next_s.ret_cnt = s.ret_cnt
                   + ((rdat_valid_i && s.ret_cnt != RET_D8) ? 8'h01 : 8'h00)
                   - ((rd_data && s.ret_cnt != 8'h00) ? 8'h01 : 8'h00);

    // modal errors only reach the error message bit, never packet error
    if (modal_err_i) begin
      next_s.modal = 1'b1;
    end
  end

  // whole state in one register; reset empties every buffer
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_full_holds;
    cmd_full && !cmd_pop |=> cmd_full && !ready_to_receive_flag_o;
  endproperty
  a_full_holds: assert property (p_full_holds) else $error("full command FIFO did not hold");

  property p_bad_id;
    wr_data && s.pst == hcpp_pkg::PK_ID && word[15:12] != `HCPP_ID_MARK |=> s.perr;
  endproperty
  a_bad_id: assert property (p_bad_id) else $error("bad identifier not flagged");

  property p_good_pkt;
    wr_data && s.pst == hcpp_pkg::PK_TERM && word == `HCPP_TERM_WORD && !cmd_full && !cmd_pop
      |=> s.cmd_cnt == $past(s.cmd_cnt) + 8'h01 && !$rose(s.perr);
  endproperty
  a_good_pkt: assert property (p_good_pkt) else $error("good packet not stored");

  property p_rts;
    rd_csr |=> rdata_o[`HCPP_CSR_RTS] == ($past(s.ret_cnt) != 8'h00);
  endproperty
  a_rts: assert property (p_rts) else $error("ready-to-send wrong");

  // read data drops to zero unless a read was taken; back-to-back reads stay legal
  property p_rdata_idle;
    !rd_i |=> rdata_o == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data stayed after its cycle");

  property p_ovf;
    rdat_valid_i && s.ret_cnt == RET_D8 |=> s.ovf && err_msg && s.ret_cnt <= RET_D8;
  endproperty
  a_ovf: assert property (p_ovf) else $error("return overflow not flagged");

  property p_exec_no_perr;
    (err_valid_i || modal_err_i) && !wr_i |=> !$rose(s.perr) ##0 err_msg;
  endproperty
  a_exec_no_perr: assert property (p_exec_no_perr) else $error("execution error misreported");

  property p_move;
    rd_i && addr_i == `HCPP_OFS_MOVE |=> rdata_o == 32'($past(s.mv_s2));
  endproperty
  a_move: assert property (p_move) else $error("move complete read mismatch");

  // after a stored packet a command is offered to the executor on the very next cycle
  property p_cmd_visible;
    wr_data && s.pst == hcpp_pkg::PK_TERM && word == `HCPP_TERM_WORD && !cmd_full |=> cmd_valid_o;
  endproperty
  a_cmd_visible: assert property (p_cmd_visible) else $error("stored command not offered");

  property p_bad_term;
    wr_data && s.pst == hcpp_pkg::PK_TERM && word != `HCPP_TERM_WORD |=> s.perr && s.pst == hcpp_pkg::PK_ID;
  endproperty
  a_bad_term: assert property (p_bad_term) else $error("bad terminator not flagged");

  property p_ret_store;
    rdat_valid_i && s.ret_cnt != RET_D8 && !rd_data |=> s.ret_cnt == $past(s.ret_cnt) + 8'h01;
  endproperty
  a_ret_store: assert property (p_ret_store) else $error("return word not stored");

  property p_err_push;
    err_valid_i |=> !stk.empty;
  endproperty
  a_err_push: assert property (p_err_push) else $error("error entry not stacked");

  property p_errmsg_clear;
    stk.pop && stk.count == 8'h01 && !err_valid_i && !s.ovf && !s.modal && !modal_err_i && !rdat_valid_i
      |=> !err_msg;
  endproperty
  a_errmsg_clear: assert property (p_errmsg_clear) else $error("error message stuck");

  c_pkt_ok:   cover property (wr_data && s.pst == hcpp_pkg::PK_TERM && word == `HCPP_TERM_WORD);
  c_pkt_err:  cover property ($rose(s.perr));
  c_cmd_full: cover property (cmd_full);
  c_ret_ovf:  cover property ($rose(s.ovf));
endmodule : hcpp_top

// ### include/hcpp_cfg.svh
// hcpp_cfg.svh: offsets, fields and sizes of the host command packet port
`ifndef HCPP_CFG_SVH
`define HCPP_CFG_SVH

// register offsets on the host port
`define HCPP_AW          4
`define HCPP_OFS_DATA    4'h0
`define HCPP_OFS_CSR     4'h4
`define HCPP_OFS_MOVE    4'h8
`define HCPP_OFS_ERR     4'hc

// communication status bits
`define HCPP_CSR_RX_RDY  5'h00
`define HCPP_CSR_RTS     5'h01
`define HCPP_CSR_PKT_ERR 5'h02
`define HCPP_CSR_ERR_MSG 5'h03
`define HCPP_CSR_RET_OVF 5'h04

// packet framing
`define HCPP_ID_MARK     4'ha
`define HCPP_TERM_WORD   16'hfffe
`define HCPP_MAX_WORDS   4

// sizes
`define HCPP_NUM_AXES    4
`define HCPP_CMD_DEPTH   16
`define HCPP_RET_DEPTH   26
`define HCPP_STK_DEPTH   30
`define HCPP_PTR_MAX     255

`endif

// ### include/hcpp_pkg.sv
// hcpp_pkg: types shared by the host command packet port
`include "hcpp_cfg.svh"
package hcpp_pkg;
  // packet checker position
  typedef enum logic [1:0] {PK_ID, PK_BODY, PK_TERM} hcpp_pkt_state_t;

  // one received command: word count and up to four words
  typedef struct packed {
    logic [2:0]                            len;
    logic [`HCPP_MAX_WORDS-1:0][15:0]      words;
  } hcpp_cmd_t;

  // one error stack entry as read by the host
  typedef struct packed {
    logic [15:0] code;
    logic [7:0]  res_id;
    logic [7:0]  cmd_id;
  } hcpp_err_t;
endpackage : hcpp_pkg

// ### include/hcpp_stk_if.sv
// hcpp_stk_if: link between the port logic and the error stack
`timescale 1ns/1ns
interface hcpp_stk_if;
  logic              push;
  logic              pop;
  hcpp_pkg::hcpp_err_t push_entry;
  hcpp_pkg::hcpp_err_t top_entry;
  logic              empty;
  logic [7:0]        count;
  modport owner (output push, output pop, output push_entry, input top_entry, input empty, input count);
  modport stack (input push, input pop, input push_entry, output top_entry, output empty, output count);
endinterface : hcpp_stk_if

// ### verilog/hcpp_err_stack.sv
// hcpp_err_stack: last-in-first-out store of execution errors
`timescale 1ns/1ns
`include "hcpp_cfg.svh"
module hcpp_err_stack #(
  parameter int DEPTH = `HCPP_STK_DEPTH
) (
  input wire logic   ref_clk_i,
  input wire logic   rst_i,
  hcpp_stk_if.stack  stk
);
  localparam logic [7:0] D8 = 8'(DEPTH);

  typedef struct packed {
    hcpp_pkg::hcpp_err_t [DEPTH-1:0] mem;
    logic [7:0]                      cnt;
  } hcpp_stk_state_t;

  hcpp_stk_state_t s;
  hcpp_stk_state_t next_s;
  logic            do_pop;
  logic            do_push;

  if (DEPTH < 1 || DEPTH > `HCPP_PTR_MAX) begin : g_chk
    $error("stack depth out of range");
  end

  // a push on a full stack is only taken when a pop frees the top
  assign do_pop  = stk.pop && (s.cnt != 8'h00);
  assign do_push = stk.push && ((s.cnt != D8) || do_pop);

  // pop and push together replace the top entry in place
  always_comb begin
    next_s = s;
    if (do_pop && do_push) begin
      next_s.mem[s.cnt - 8'h01] = stk.push_entry;
    end else if (do_pop) begin
      next_s.cnt = s.cnt - 8'h01;
    end else if (do_push) begin
      next_s.mem[s.cnt] = stk.push_entry;
      next_s.cnt        = s.cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // newest entry is always the one presented
  assign stk.top_entry = (s.cnt != 8'h00) ? s.mem[s.cnt - 8'h01] : '0;
  assign stk.empty     = (s.cnt == 8'h00);
  assign stk.count     = s.cnt;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_lifo_newest;
    stk.push && !stk.pop && (s.cnt != D8) |=> stk.top_entry == $past(stk.push_entry);
  endproperty
  a_lifo_newest: assert property (p_lifo_newest) else $error("pushed entry not on top");

  property p_full_drop;
    (s.cnt == D8) && stk.push && !stk.pop |=> (s.cnt == D8) && $stable(stk.top_entry);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("full stack changed on push");

  property p_older_next;
    (s.cnt >= 8'h02) && stk.pop && !stk.push |=> stk.top_entry == $past(s.mem[s.cnt - 8'h02]);
  endproperty
  a_older_next: assert property (p_older_next) else $error("pop did not expose older entry");

  c_stack_full: cover property (s.cnt == D8 && stk.push);
endmodule : hcpp_err_stack

// ### verification/hcpp_host_model.sv
// hcpp_host_model: host computer that drives the packet port register bus
`timescale 1ns/1ns
`include "hcpp_cfg.svh"
module hcpp_host_model (
  input  wire logic            ref_clk_i,
  input  wire logic            ready_to_receive_flag_i,
  output logic [`HCPP_AW-1:0]  addr_o,
  output logic [31:0]          wdata_o,
  output logic                 wr_o,
  output logic                 rd_o
);
  logic [31:0] exp_q[$];  // read results still owed by the port
  int          hangs = 0; // words that never found room

  // idle bus at time zero
  initial begin
    addr_o  = '0;
    wdata_o = '0;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // one strobe cycle; qualifiers are scrambled after it so stale values mean nothing
  task automatic bus_cycle(input logic [`HCPP_AW-1:0] a, input logic [31:0] d, input logic w);
    @(posedge ref_clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= w;
    rd_o    <= !w;
    @(posedge ref_clk_i);
    addr_o  <= ~a;
    wdata_o <= ~d;
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
  endtask : bus_cycle

  // a read notes what the port owes; the bench monitor checks it
  task automatic rd_reg(input logic [`HCPP_AW-1:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus_cycle(a, 32'h0000_0000, 1'b0);
  endtask : rd_reg

  // sample ready-to-receive between edges, so the flag has settled, before every word
  task automatic send_word(input logic [15:0] w);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    while (ready_to_receive_flag_i !== 1'b1 && n < 2000) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 2000) hangs++;
    bus_cycle(`HCPP_OFS_DATA, {16'h0000, w}, 1'b1);
  endtask : send_word

  // identifier word, its count of body words, then the closing word
  task automatic send_pkt(input logic [15:0] id, input logic [3:0][15:0] w, input logic [15:0] term);
    send_word(id);
    for (int i = 0; i < 4; i++) begin
      if (i < id[2:0]) send_word(w[i]);
    end
    send_word(term);
  endtask : send_pkt
endmodule : hcpp_host_model

// ### verification/tb_top.sv
// tb_top: self-checking bench of the host command packet port
`timescale 1ns/1ns
`include "hcpp_cfg.svh"
module tb_top;
  logic                 ref_clk_i    = 1'b0;
  logic                 rst_i        = 1'b1;
  logic [`HCPP_AW-1:0]  addr_i;
  logic [31:0]          wdata_i;
  logic                 wr_i;
  logic                 rd_i;
  logic [31:0]          rdata_o;
  logic                 ready_to_receive_flag_o;
  logic [3:0]           move_done_i  = 4'h0;
  logic                 cmd_valid_o;
  hcpp_pkg::hcpp_cmd_t  cmd_o;
  logic                 cmd_ready_i  = 1'b0;
  logic                 modal_err_i  = 1'b0;
  logic                 rdat_valid_i = 1'b0;
  logic [15:0]          rdat_word_i  = 16'h0000;
  logic                 err_valid_i  = 1'b0;
  hcpp_pkg::hcpp_err_t  err_entry_i  = '0;
  logic                 exec_go      = 1'b1;
  logic                 rd_seen      = 1'b0;
  int                   fails        = 0;
  int                   n_compared   = 0;
  int                   cycles       = 0;
  hcpp_pkg::hcpp_cmd_t  cmd_q[$];
  logic [31:0]          v;
  logic [15:0]          rw[27];
  logic [31:0]          ents[31];

  hcpp_top hcpp_top_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ready_to_receive_flag_o(ready_to_receive_flag_o),
    .move_done_i(move_done_i), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .cmd_ready_i(cmd_ready_i),
    .modal_err_i(modal_err_i), .rdat_valid_i(rdat_valid_i), .rdat_word_i(rdat_word_i),
    .err_valid_i(err_valid_i), .err_entry_i(err_entry_i));
  hcpp_host_model hcpp_host_model_inst (.ref_clk_i(ref_clk_i), .ready_to_receive_flag_i(ready_to_receive_flag_o),
    .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

  // 25 MHz clock
  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // executor accepts at random, so pops come both back to back and spaced
  always @(posedge ref_clk_i) cmd_ready_i <= exec_go && $urandom_range(1, 0) == 1;

  // monitor: read data one cycle after the strobe, commands on each accepted pop
  always @(posedge ref_clk_i) begin
    cycles  <= cycles + 1;
    rd_seen <= rd_i;
    if (rd_seen) cmp_rd(rdata_o);
    if (cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1) cmp_cmd(cmd_o);
    if (cycles == 20000) begin
      miss("timeout");
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task automatic miss(input string m);
    fails++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : miss

  task automatic cmp_rd(input logic [31:0] got);
    logic [31:0] e;
    n_compared++;
    if (hcpp_host_model_inst.exp_q.size() == 0) begin
      miss("read data with no read owed");
      return;
    end
    e = hcpp_host_model_inst.exp_q.pop_front();
    if (got !== e) miss($sformatf("read data %h expected %h", got, e));
  endtask : cmp_rd

  // only the words that the length covers are compared
  task automatic cmp_cmd(input hcpp_pkg::hcpp_cmd_t got);
    hcpp_pkg::hcpp_cmd_t e;
    logic                bad;
    n_compared++;
    if (cmd_q.size() == 0) begin
      miss("command appeared with none sent");
      return;
    end
    e   = cmd_q.pop_front();
    bad = got.len !== e.len;
    for (int i = 0; i < 4; i++) begin
      if (i < e.len && got.words[i] !== e.words[i]) bad = 1'b1;
    end
    if (bad) miss($sformatf("command %h expected %h", got, e));
  endtask : cmp_cmd

  task automatic rd(input logic [`HCPP_AW-1:0] a, input logic [31:0] e);
    hcpp_host_model_inst.rd_reg(a, e);
  endtask : rd

  // status value built from the bit positions of the port; b is {overflow, message, packet, send, receive}
  function automatic logic [31:0] csr(input logic [4:0] b);
    csr                    = 32'h0000_0000;
    csr[`HCPP_CSR_RX_RDY]  = b[0];
    csr[`HCPP_CSR_RTS]     = b[1];
    csr[`HCPP_CSR_PKT_ERR] = b[2];
    csr[`HCPP_CSR_ERR_MSG] = b[3];
    csr[`HCPP_CSR_RET_OVF] = b[4];
  endfunction : csr

  task automatic good_pkt(input logic [2:0] n);
    hcpp_pkg::hcpp_cmd_t c;
    c.len   = n;
    c.words = {$urandom, $urandom};
    cmd_q.push_back(c);
    hcpp_host_model_inst.send_pkt({`HCPP_ID_MARK, 9'h000, n}, c.words, `HCPP_TERM_WORD);
  endtask : good_pkt

  // one-cycle event from the executor: 0 modal error, 1 return word, 2 error entry
  task automatic pulse(input int k, input logic [31:0] d);
    @(posedge ref_clk_i);
    modal_err_i  <= k == 0;
    rdat_valid_i <= k == 1;
    err_valid_i  <= k == 2;
    rdat_word_i  <= d[15:0];
    err_entry_i  <= d;
    @(posedge ref_clk_i);
    {modal_err_i, rdat_valid_i, err_valid_i} <= 3'b000;
  endtask : pulse

  task automatic drain();
    while (cmd_q.size() != 0) @(posedge ref_clk_i);
  endtask : drain

  initial begin
    void'($urandom(7));
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // empty after reset; status writes and unmapped places are ignored
    rd(`HCPP_OFS_CSR, csr(5'h01));
    rd(`HCPP_OFS_DATA, 32'h0000_0000);
    rd(`HCPP_OFS_ERR, 32'h0000_0000);
    hcpp_host_model_inst.bus_cycle(`HCPP_OFS_CSR, 32'hffff_ffff, 1'b1);
    hcpp_host_model_inst.bus_cycle(4'h2, 32'hffff_ffff, 1'b1);
    rd(`HCPP_OFS_CSR, csr(5'h01));
    rd(4'h2, 32'h0000_0000);
    // move complete levels after the two-stage synchroniser
    repeat (3) begin
      v = $urandom;
      @(posedge ref_clk_i);
      move_done_i <= v[3:0];
      repeat (3) @(posedge ref_clk_i);
      rd(`HCPP_OFS_MOVE, {28'h000_0000, v[3:0]});
    end
    // every packet length, then random ones
    for (int n = 1; n <= 4; n++) good_pkt(n[2:0]);
    repeat (4) good_pkt(3'($urandom_range(4, 1)));
    // bad identifier, then wrong terminator; the next good packet still lands
    hcpp_host_model_inst.send_word(16'h1234);
    rd(`HCPP_OFS_CSR, csr(5'h05));
    rd(`HCPP_OFS_CSR, csr(5'h01));
    hcpp_host_model_inst.send_pkt({`HCPP_ID_MARK, 12'h002}, 64'h0, 16'h1111);
    rd(`HCPP_OFS_CSR, csr(5'h05));
    good_pkt(3'h2);
    drain();
    // fill sixteen commands with the executor stalled, then the host waits for room
    @(posedge ref_clk_i);
    exec_go <= 1'b0;
    repeat (16) good_pkt(3'h1);
    rd(`HCPP_OFS_CSR, csr(5'h00));
    fork
      good_pkt(3'h4);
      begin
        repeat (30) @(posedge ref_clk_i);
        exec_go <= 1'b1;
      end
    join
    drain();
    // return data: twenty-six fit, the twenty-seventh overflows
    for (int i = 0; i < 27; i++) begin
      v     = $urandom;
      rw[i] = v[15:0];
      pulse(1, v);
      if (i == 0) rd(`HCPP_OFS_CSR, csr(5'h03));
    end
    rd(`HCPP_OFS_CSR, csr(5'h1b));
    for (int i = 0; i < 26; i++) rd(`HCPP_OFS_DATA, {16'h0000, rw[i]});
    rd(`HCPP_OFS_CSR, csr(5'h01));
    // modal error raises the message bit only
    pulse(0, 32'h0000_0000);
    rd(`HCPP_OFS_CSR, csr(5'h09));
    rd(`HCPP_OFS_CSR, csr(5'h01));
    // thirty-one errors: the last is dropped, reads come newest first
    for (int i = 0; i < 31; i++) begin
      ents[i] = $urandom;
      pulse(2, ents[i]);
    end
    rd(`HCPP_OFS_CSR, csr(5'h09));
    for (int i = 29; i >= 0; i--) begin
      rd(`HCPP_OFS_ERR, ents[i]);
      if (i == 1) rd(`HCPP_OFS_CSR, csr(5'h09));
    end
    rd(`HCPP_OFS_CSR, csr(5'h01));
    // reset in mid-run empties everything again
    @(posedge ref_clk_i);
    exec_go <= 1'b0;
    good_pkt(3'h1);
    pulse(1, 32'h0000_00a5);
    pulse(2, 32'h0000_005a);
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cmd_q.delete();
    exec_go <= 1'b1;
    rd(`HCPP_OFS_CSR, csr(5'h01));
    rd(`HCPP_OFS_DATA, 32'h0000_0000);
    rd(`HCPP_OFS_ERR, 32'h0000_0000);
    repeat (8) @(posedge ref_clk_i);
    if (hcpp_host_model_inst.hangs != 0) miss("host never saw room");
    end_of_test();
  end
endmodule : tb_top
